/* design/cmf_defs.vh */
`ifndef CMF_DEFS_VH
`define CMF_DEFS_VH
// register byte offsets
`define CMF_OFS_CTRL0 8'h00
`define CMF_OFS_CTRL1 8'h04
`define CMF_OFS_START 8'h08
`define CMF_OFS_STAT 8'h0C
// comparator_control field positions
`define CMF_F_ENABLE 0
`define CMF_F_SINGLE 1
`define CMF_F_HYST 2
`define CMF_F_SPEED_LO 3
`define CMF_F_FILTER_LENGTH_LO 5
`define CMF_CTRL_W 8
`define CMF_CTRL_RESET 8'h00
// filter_length encodings
`define CMF_FILTER_LENGTH_OFF 2'h0
`define CMF_FILTER_LENGTH_3 2'h1
`define CMF_FILTER_LENGTH_5 2'h2
// sampling tick divider default (comparator_generic_clock = aclk / div)
`define CMF_SAMPLE_DIV 16'h0001
// axi responses
`define CMF_RESP_OKAY 2'h0
`define CMF_RESP_SLVERR 2'h2
`endif

/* design/cmf_chan.v */
`timescale 1ns/1ns
`default_nettype none
`include "cmf_defs.vh"
// one comparator's majority filter and validation sequencing
module cmf_chan (
   input wire aclk,
   input wire aresetn,
   input wire sample_tick,
   input wire enable,
   input wire single,
   input wire [1:0] filter_length,
   input wire start,
   input wire raw_in,
   output reg filt_out,
   output reg valid,
   output reg done
);
   reg [4:0] hist_r;
   reg [2:0] cnt_r;
   reg busy_r;
   wire [4:0] win;
   wire [2:0] ones3;
   wire [2:0] ones5;
   wire [2:0] need;
   wire vote;
   wire [2:0] cnt_inc;

   // current sample plus previous samples, newest in bit 0
   assign win = {hist_r[3:0], raw_in};
   assign ones3 = {2'b00, win[0]} + {2'b00, win[1]} + {2'b00, win[2]};
   assign ones5 = ones3 + {2'b00, win[3]} + {2'b00, win[4]};
   // samples needed before output is valid
   assign need = (filter_length == `CMF_FILTER_LENGTH_5) ? 3'd5 :
                 (filter_length == `CMF_FILTER_LENGTH_3) ? 3'd3 : 3'd1;
   // majority of N/2+1
   assign vote = (filter_length == `CMF_FILTER_LENGTH_5) ? (ones5 >= 3'd3) :
                 (filter_length == `CMF_FILTER_LENGTH_3) ? (ones3 >= 3'd2) : raw_in;
   assign cnt_inc = cnt_r + 3'd1;

   // one sample per sampling tick
   always @(posedge aclk) begin
      if (!aresetn) begin
         hist_r <= 5'h0_0;
         cnt_r <= 3'd0;
         busy_r <= 1'b0;
         filt_out <= 1'b0;
         valid <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (!enable) begin
            cnt_r <= 3'd0;
            busy_r <= 1'b0;
            valid <= 1'b0;
         end else if (single && start) begin
            // a new single shot discards old samples
            cnt_r <= 3'd0;
            busy_r <= 1'b1;
            valid <= 1'b0;
         end else if (sample_tick && (!single || busy_r)) begin
            hist_r <= win[4:0];
            if (cnt_inc >= need) begin
               // continuous: every tick after the first full window
               filt_out <= vote;
               valid <= 1'b1;
               if (single) begin
                  busy_r <= 1'b0;
                  done <= 1'b1;
                  cnt_r <= 3'd0;
               end
            end else begin
               cnt_r <= cnt_inc;
            end
         end
      end
   end
endmodule // cmf_chan
`default_nettype wire

/* design/cmf_top.v */
`timescale 1ns/1ns
`default_nettype none
`include "cmf_defs.vh"
////////////////////////////////////////////////////////////////////////////////
// register map, one 32-bit word per register, byte offsets
//   0x00 control, comparator 0
//   0x04 control, comparator 1
//      bit 0     enable the comparator and its filter
//      bit 1     single shot; 0 runs continuously
//      bit 2     hysteresis request, masked while single shot is set
//      bits 4:3  speed, handed to the bias selection of the core
//      bits 6:5  filter length: 0 none, 1 three samples, 2 five samples
//                3 is not a length and behaves as none
//   0x08 start and sampling divider
//      bits 1:0   write one to start a single shot on that comparator
//      bits 31:16 sampling divider, 0 or 1 samples on every clock
//   0x0c status
//      bits 1:0  filtered outputs
//      bits 3:2  filtered output valid
//      bits 7:6  single shot done, sticky; write one to clear
// other offsets answer with an error response and read as zero
//
// timing seen from the bus
//   a write lands one cycle after both halves are taken; the response
//   rises in that same cycle and waits for the master
//   a read answers two cycles after the address is offered
//   hysteresis, speed and enable reach the pins one cycle after a write
// limitation: the divider is shared by both comparators, so both filters
//   always sample at the same rate
////////////////////////////////////////////////////////////////////////////////
module cmf_top #(
   parameter NCMP = 2
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [NCMP-1:0] cmp_raw,
   output reg [NCMP-1:0] cmp_filtered,
   output reg [NCMP-1:0] cmp_valid,
   output reg [NCMP-1:0] cmp_done_pulse,
   output reg [NCMP-1:0] cmp_enable,
   output reg [NCMP-1:0] hysteresis_enable,
   output reg [2*NCMP-1:0] cmp_speed
);
   reg [`CMF_CTRL_W-1:0] ctrl_r [0:1];
   reg [15:0] div_r;
   reg [15:0] divcnt_r;
   reg tick_r;
   reg [NCMP-1:0] start_r;
   reg [NCMP-1:0] done_sticky_r;
   reg [7:0] awaddr_r;
   reg aw_have_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   reg w_have_r;
   wire [NCMP-1:0] f_out;
   wire [NCMP-1:0] f_valid;
   wire [NCMP-1:0] f_done;
   wire do_write;
   wire [7:0] wb;
   wire wr_addr_ok;
   integer j;
   reg [31:0] rd_nxt;
   reg rd_err_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // sampling tick: stands in for the comparator digital generic clock
   // a divider of 0 or 1 gives a tick on every clock; a larger value slows
   // both filters alike, trading response time for rejection of slow noise
   // the tick is a flop, so the channels see a clean one-cycle strobe
   always @(posedge aclk) begin
      if (!aresetn) begin
         divcnt_r <= 16'h0000;
         tick_r <= 1'b0;
      end else if (divcnt_r + 16'h0001 >= div_r) begin
         divcnt_r <= 16'h0000;
         tick_r <= 1'b1;
      end else begin
         divcnt_r <= divcnt_r + 16'h0001;
         tick_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // filter channels, one per comparator
   // each channel keeps its own history, so the setting of one comparator
   // never disturbs the samples of the other
   genvar g;
   generate
      for (g = 0; g < NCMP; g = g + 1) begin : g_ch
         cmf_chan u_ch (
            .aclk(aclk),
            .aresetn(aresetn),
            .sample_tick(tick_r),
            .enable(ctrl_r[g][`CMF_F_ENABLE]),
            .single(ctrl_r[g][`CMF_F_SINGLE]),
            .filter_length(ctrl_r[g][`CMF_F_FILTER_LENGTH_LO+1:`CMF_F_FILTER_LENGTH_LO]),
            .start(start_r[g]),
            .raw_in(cmp_raw[g]),
            .filt_out(f_out[g]),
            .valid(f_valid[g]),
            .done(f_done[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs toward the analog cores
   // every pin comes straight from a flop, one cycle behind the channel or the control register
   // speed is two bits per comparator, comparator 0 in the low pair
   integer i;
   always @(posedge aclk) begin
      if (!aresetn) begin
         cmp_filtered <= {NCMP{1'b0}};
         cmp_valid <= {NCMP{1'b0}};
         cmp_done_pulse <= {NCMP{1'b0}};
         cmp_enable <= {NCMP{1'b0}};
         hysteresis_enable <= {NCMP{1'b0}};
         cmp_speed <= {2*NCMP{1'b0}};
      end else begin
         cmp_filtered <= f_out;
         cmp_valid <= f_valid;
         cmp_done_pulse <= f_done;
         for (i = 0; i < NCMP; i = i + 1) begin
            cmp_enable[i] <= ctrl_r[i][`CMF_F_ENABLE];
            // hysteresis is masked in single-shot mode
            hysteresis_enable[i] <= ctrl_r[i][`CMF_F_HYST] &
                                    ~ctrl_r[i][`CMF_F_SINGLE];
            cmp_speed[2*i +: 2] <= ctrl_r[i][`CMF_F_SPEED_LO+1:`CMF_F_SPEED_LO];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi-lite write: address and data captured in either order
   // each ready pulses for one cycle, so a valid that is held is taken once;
   // the write lands only when both halves are in and no response is pending
   assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
   // only byte lane 0 carries control, start and clear bits
   assign wb = wstrb_r[0] ? wdata_r[7:0] : 8'h00;
   // any other offset is answered with an error and changes nothing
   assign wr_addr_ok = (awaddr_r == `CMF_OFS_CTRL0) || (awaddr_r == `CMF_OFS_CTRL1) ||
                       (awaddr_r == `CMF_OFS_START) || (awaddr_r == `CMF_OFS_STAT);

   // write address channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         aw_have_r <= 1'b0;
         awaddr_r <= 8'h00;
      end else begin
         s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (do_write) begin
            aw_have_r <= 1'b0;
         end
      end
   end

   // write data channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b0;
         w_have_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else begin
         s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (do_write) begin
            w_have_r <= 1'b0;
         end
      end
   end

   // write response: held until the master takes it
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CMF_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_addr_ok ? `CMF_RESP_OKAY : `CMF_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers, sampling divider and single-shot start strobes
   // control bytes are taken whole; software keeps unused bits at zero
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r[0] <= `CMF_CTRL_RESET;
         ctrl_r[1] <= `CMF_CTRL_RESET;
         div_r <= `CMF_SAMPLE_DIV;
         start_r <= {NCMP{1'b0}};
      end else begin
         // start strobes last one cycle
         start_r <= {NCMP{1'b0}};
         if (do_write) begin
            case (awaddr_r)
               `CMF_OFS_CTRL0: if (wstrb_r[0]) ctrl_r[0] <= wdata_r[7:0];
               `CMF_OFS_CTRL1: if (wstrb_r[0]) ctrl_r[1] <= wdata_r[7:0];
               `CMF_OFS_START: begin
                  // start bits for single shot, divider in upper half
                  start_r <= wb[NCMP-1:0];
                  if (wstrb_r[2]) div_r[7:0] <= wdata_r[23:16];
                  if (wstrb_r[3]) div_r[15:8] <= wdata_r[31:24];
               end
               default: ;
            endcase
         end
      end
   end

   // completions set the sticky done bits; set wins over clear
   // a clear that meets a completion in one cycle is dropped on purpose,
   // so software never loses a result; clear bits sit where status reads them
   always @(posedge aclk) begin
      if (!aresetn) begin
         done_sticky_r <= {NCMP{1'b0}};
      end else begin
         for (j = 0; j < NCMP; j = j + 1) begin
            if (f_done[j])
               done_sticky_r[j] <= 1'b1;
            else if (do_write && awaddr_r == `CMF_OFS_STAT && wb[6+j])
               done_sticky_r[j] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   // decoded from the live address; the read process below registers it
   always @* begin
      rd_nxt = 32'h0000_0000;
      rd_err_nxt = 1'b0;
      case (s_axi_araddr)
         `CMF_OFS_CTRL0: rd_nxt[7:0] = ctrl_r[0];
         `CMF_OFS_CTRL1: rd_nxt[7:0] = ctrl_r[1];
         `CMF_OFS_START: rd_nxt[31:16] = div_r;
         `CMF_OFS_STAT: rd_nxt[7:0] = {done_sticky_r[1:0], 2'b00,
                                        f_valid[1:0], f_out[1:0]};
         default: rd_err_nxt = 1'b1;
      endcase
   end

   // axi-lite read: one outstanding, answer two edges after arvalid
   // arready pulses once, and a new address is refused while rvalid waits,
   // so rdata and rresp stand unchanged until rready takes them
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `CMF_RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_nxt;
            s_axi_rresp <= rd_err_nxt ? `CMF_RESP_SLVERR : `CMF_RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // cmf_top
`default_nettype wire

/* dv/cmf_comparator_model.sv */
`timescale 1ns/1ns
`default_nettype none
// comparator pair: bench sets the analog level, glitch adds noise
module cmf_comparator_model (
   input wire logic aclk,
   input wire logic [1:0] cmp_enable,
   input wire logic [1:0] level,
   input wire logic [1:0] glitch,
   output logic [1:0] cmp_raw
);
   // re-timed to aclk; a disabled core reads low, no stale level
   always_ff @(posedge aclk) cmp_raw <= cmp_enable & (level ^ glitch);
endmodule // cmf_comparator_model
`default_nettype wire

/* dv/cmf_top_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// port-level relations of the filter block
module cmf_top_monitor #(
   parameter NCMP = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [NCMP-1:0] cmp_raw,
   input wire logic [NCMP-1:0] cmp_filtered,
   input wire logic [NCMP-1:0] cmp_valid,
   input wire logic [NCMP-1:0] cmp_done_pulse,
   input wire logic [NCMP-1:0] cmp_enable
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [15:0] hist_r;
   // deep enough to cover the longest vote plus the output staging
   always_ff @(posedge aclk) hist_r <= {hist_r[14:0], cmp_raw[0]};
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   property p_wr_resp; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("late bvalid");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
   property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
   a_aw_pulse: assert property (p_aw_pulse) else $error("awready stuck");
   property p_done_one; cmp_done_pulse[0] |=> !cmp_done_pulse[0]; endproperty
   a_done_one: assert property (p_done_one) else $error("done too long");
   property p_done_en; $rose(cmp_done_pulse[0]) |-> $past(cmp_enable[0], 2); endproperty
   a_done_en: assert property (p_done_en) else $error("done while off");
   property p_valid_en; $rose(cmp_valid[0]) |-> $past(cmp_enable[0]); endproperty
   a_valid_en: assert property (p_valid_en) else $error("early valid");
   property p_rise_src; $rose(cmp_filtered[0]) |-> |hist_r; endproperty
   a_rise_src: assert property (p_rise_src) else $error("rise from nothing");
   property p_rst_clear; $rose(aresetn) |-> cmp_valid == 0 && cmp_done_pulse == 0; endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared");
endmodule // cmf_top_monitor
bind cmf_top cmf_top_monitor #(.NCMP(NCMP)) u_mon (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .cmp_raw,
   .cmp_filtered, .cmp_valid, .cmp_done_pulse, .cmp_enable);
`default_nettype wire

/* dv/test_comparator_output_majority_filter.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cmf_defs.vh"
module test_comparator_output_majority_filter;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, dropped;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat, v;
   logic [3:0] s_axi_wstrb = 4'hf, cmp_speed;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp, cmp_raw, cmp_filtered, cmp_valid;
   logic [1:0] cmp_done_pulse, cmp_enable, hysteresis_enable, level = 0, glitch = 0;
   int miscompares = 0, checks_done = 0, cyc = 0, n, lat[3], lats[3];
   integer seed = 32'hb67f;
   cmf_top dut (.*);
   cmf_comparator_model partner (.aclk, .cmp_enable, .level, .glitch, .cmp_raw);
   // 100 MHz clock
   always #5 aclk = ~aclk;
   // hang guard, far above the few hundred cycles needed
   always @(posedge aclk) begin
      if (++cyc == 20000) begin
         miscompares++;
         results();
      end
   end
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // samples a glitch must span to flip an N-sample vote
   function automatic int nmaj(input int f);
      return (2 * f + 1) / 2 + 1;
   endfunction
   // address and data offered together, either may be taken first
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit ta = 0, tw = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(ta && tw)) begin
         @(posedge aclk);
         ta = ta | s_axi_awready;
         tw = tw | s_axi_wready;
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_rvalid);
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic results;
      $display("checks %0d, miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////
   // reset, unmapped read, then each filter length, single shot, controls
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`CMF_OFS_CTRL0);
      chk(rdat, 0);
      rd(8'h10);
      chk({rdat[29:0], resp}, `CMF_RESP_SLVERR);
      $display("test regs end");
      level <= 2'b11;
      for (int f = 0; f < 3; f++) begin
         wr(`CMF_OFS_CTRL0, 32'(f << 5 | 1));
         for (n = 0; !cmp_valid[0]; n++) @(posedge aclk);
         lat[f] = n;
         // glitch one sample short of a majority, then exactly a majority
         for (int k = 0; k < 2; k++) begin
            repeat (8) @(posedge aclk);
            chk(cmp_filtered[0], 1);
            dropped = 0;
            for (int i = 0; i < 12; i++) begin
               glitch <= {1'b0, i < nmaj(f) - 1 + k};
               @(posedge aclk);
               dropped |= !cmp_filtered[0];
            end
            chk(dropped, k);
         end
         wr(`CMF_OFS_CTRL0, 0);
      end
      chk(lat[1] - lat[0], 2);
      chk(lat[2] - lat[1], 2);
      $display("test filter end");
      for (int f = 1; f < 3; f++) begin
         wr(`CMF_OFS_CTRL0, 32'(f << 5 | 3));
         wr(`CMF_OFS_START, 1);
         for (n = 0; !cmp_done_pulse[0]; n++) @(posedge aclk);
         lats[f] = n;
      end
      chk(lats[2] - lats[1], 2);
      rd(`CMF_OFS_STAT);
      chk(rdat[7:6], 1);
      wr(`CMF_OFS_STAT, 32'h0000_00c0);
      rd(`CMF_OFS_STAT);
      chk(rdat[7:6], 0);
      // second comparator on its own: continuous five-sample, then single shot
      level <= 2'b10;
      wr(`CMF_OFS_CTRL0, 0);
      wr(`CMF_OFS_CTRL1, 32'h0000_0041);
      repeat (12) @(posedge aclk);
      chk(cmp_valid, 2'b10);
      chk(cmp_filtered[1], 1);
      wr(`CMF_OFS_CTRL1, 32'h0000_0023);
      wr(`CMF_OFS_START, 2);
      for (n = 0; !cmp_done_pulse[1]; n++) @(posedge aclk);
      chk(n, lats[1]);
      $display("test single end");
      for (int i = 0; i < 5; i++) begin
         v = i ? $random(seed) : 32'h0000_0406;
         level <= v[17:16];
         wr(`CMF_OFS_CTRL0, v[4:0]);
         wr(`CMF_OFS_CTRL1, v[12:8]);
         repeat (2) @(posedge aclk);
         chk(hysteresis_enable, {v[10] & ~v[9], v[2] & ~v[1]});
         chk(cmp_speed, {v[12:11], v[4:3]});
         chk(cmp_enable, {v[8], v[0]});
      end
      // sampling divider lives in the upper half of the start word
      wr(`CMF_OFS_START, 32'h0003_0000);
      rd(`CMF_OFS_START);
      chk(rdat, 32'h0003_0000);
      chk(resp, `CMF_RESP_OKAY);
      $display("test control end");
      results();
   end
endmodule // test_comparator_output_majority_filter
`default_nettype wire
